/* File: hw/adpc_top.v */
// Summary of operation
// [R1] Limiter input: 0 max, 1 channel one, 2 channel zero, 3 average.
// [R2] Limiter output: 0 both channels, 1 channel one, 2 channel zero, 3 none.
// [R3] Reserved bits read zero; software writes them as zero.
// [R4] Bits 7..4 of gain register enable gain control channels 1..4.
// [R5] Bits 3..0 of gain register enable compression channels 1..4.
// [R6] Battery limiter runs only while its enable bit 7 is set.
// [R7] Attenuation field bits 6..4 selects 0 dB to -42 dB in 6 dB steps.
// [R8] Bit 3 low: pin and field set attenuation; high: table of analog samples.
// [R9] Bit 2 low: attenuation never drops; high: drops when pin low or recovered.
// [R10] Mixer enables: interface bit 7, side-chain 6, recording 5, loopback 4.
// [R11] Distortion limiter enabled by bit 7 of feature register.
// [R12] Overprotection enabled by bit 6; range compressor enabled by bit 4.
// [R13] Thermal foldback enabled by bit 5 of feature register.
// [R14] Signal generator 1 from bit 3, generator 2 from bit 2.
// [R15] Bit 1 selects battery (0) or analog supply (1) samples for processing.
// [R16] Undervoltage shutdown enabled by bit 0 of feature register.
// [R17] Enabled shutdown trips when selected supply falls below threshold, reset 0xBF.
// [R18] Configuration changes reach processing only at a sample boundary.
`include "adpc_consts.vh"
`default_nettype none
module adpc_top #(
	parameter SAMPLE_W = 16
) (
	// Clock and reset
	input  wire                clk_in,
	input  wire                srst_in,
	// Register port
	input  wire                reg_wr_in,
	input  wire                reg_rd_in,
	input  wire [7:0]          reg_addr_in,
	input  wire [7:0]          reg_wdata_in,
	output reg  [7:0]          reg_rdata_out,
	output reg                 reg_hit_out,
	// Sample boundary strobe
	input  wire                sample_tick_in,
	// Playback samples
	input  wire [SAMPLE_W-1:0] playback_input_zero,
	input  wire [SAMPLE_W-1:0] playback_input_one,
	// Power limiter inputs
	input  wire                limiter_gpio_in,
	input  wire [7:0]          analog_pin_sample_in,
	// Supply samples
	input  wire [7:0]          battery_sample_in,
	input  wire [7:0]          analog_supply_sample_in,
	// Peak limiter routing
	output reg  [SAMPLE_W-1:0] peak_level_out,
	output reg                 limit_ch0_out,
	output reg                 limit_ch1_out,
	// Channel enables
	output reg  [3:0]          gain_ctrl_on_out,
	output reg  [3:0]          compress_on_out,
	// Battery limiter
	output reg                 battery_limiter_on_out,
	output reg  [2:0]          battery_limiter_attenuation_out,
	output reg  [5:0]          attenuation_db_out,
	// Mixers
	output reg  [3:0]          mixer_on_out,
	// Features
	output reg                 distortion_on_out,
	output reg                 battery_overprotect_on_out,
	output reg                 thermal_foldback_on_out,
	output reg                 range_compressor_on_out,
	output reg                 generator1_on_out,
	output reg                 generator2_on_out,
	output reg  [7:0]          supply_measure_out,
	output reg                 undervoltage_shutdown_out
);
	// ==================================================
	// Registers
	reg [7:0] peak_limiter_routing;
	reg [7:0] gain_compress_channel_enables;
	reg [7:0] power_limit_config;
	reg [7:0] mixer_enables;
	reg [7:0] protection_feature_enables;
	reg [7:0] undervoltage_threshold;

	// Reserved bits are stored as zero whatever is written
	always @(posedge clk_in) begin
		if (srst_in) begin
			peak_limiter_routing          <= `ADPC_RST_LIMITER;
			gain_compress_channel_enables <= `ADPC_RST_GAIN_COMP;
			power_limit_config            <= `ADPC_RST_BATTERY_POWER_LIMITER;
			mixer_enables                 <= `ADPC_RST_MIXER;
			protection_feature_enables    <= `ADPC_RST_FEATURE;
			undervoltage_threshold        <= `ADPC_RST_THRESHOLD;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `ADPC_ADDR_LIMITER) begin
				peak_limiter_routing <= reg_wdata_in & `ADPC_MASK_LIMITER; // see [R3]
			end else if (reg_addr_in == `ADPC_ADDR_GAIN_COMP) begin
				gain_compress_channel_enables <= reg_wdata_in;
			end else if (reg_addr_in == `ADPC_ADDR_BATTERY_POWER_LIMITER) begin
				power_limit_config <= reg_wdata_in & `ADPC_MASK_BATTERY_POWER_LIMITER; // see [R3]
			end else if (reg_addr_in == `ADPC_ADDR_MIXER) begin
				mixer_enables <= reg_wdata_in & `ADPC_MASK_MIXER; // see [R3]
			end else if (reg_addr_in == `ADPC_ADDR_FEATURE) begin
				protection_feature_enables <= reg_wdata_in;
			end else if (reg_addr_in == `ADPC_ADDR_THRESHOLD) begin
				undervoltage_threshold <= reg_wdata_in;
			end
		end
	end

	// ==================================================
	// Read path, one cycle latency; unmapped reads return zero
	reg [7:0] next_rdata;
	reg       next_hit;
	always @* begin
		next_rdata = 8'h00;
		next_hit   = 1'b1;
		if (reg_addr_in == `ADPC_ADDR_LIMITER) begin
			next_rdata = peak_limiter_routing;
		end else if (reg_addr_in == `ADPC_ADDR_GAIN_COMP) begin
			next_rdata = gain_compress_channel_enables;
		end else if (reg_addr_in == `ADPC_ADDR_BATTERY_POWER_LIMITER) begin
			next_rdata = power_limit_config;
		end else if (reg_addr_in == `ADPC_ADDR_MIXER) begin
			next_rdata = mixer_enables;
		end else if (reg_addr_in == `ADPC_ADDR_FEATURE) begin
			next_rdata = protection_feature_enables;
		end else if (reg_addr_in == `ADPC_ADDR_THRESHOLD) begin
			next_rdata = undervoltage_threshold;
		end else begin
			next_hit = 1'b0;
		end
	end

	always @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= 8'h00;
			reg_hit_out   <= 1'b0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
			reg_hit_out   <= next_hit;
		end
	end

	// ==================================================
	// Shadow copies taken at sample boundary
	// Avoids a sample seeing half of a multi-register update
	reg [7:0] sh_route;
	reg [7:0] sh_gain;
	reg [7:0] sh_battery_power_limiter;
	reg [7:0] sh_mix;
	reg [7:0] sh_feat;
	reg [7:0] sh_thr;
	always @(posedge clk_in) begin
		if (srst_in) begin
			sh_route <= `ADPC_RST_LIMITER;
			sh_gain  <= `ADPC_RST_GAIN_COMP;
			sh_battery_power_limiter  <= `ADPC_RST_BATTERY_POWER_LIMITER;
			sh_mix   <= `ADPC_RST_MIXER;
			sh_feat  <= `ADPC_RST_FEATURE;
			sh_thr   <= `ADPC_RST_THRESHOLD;
		end else if (sample_tick_in) begin // see [R18]
			sh_route <= peak_limiter_routing;
			sh_gain  <= gain_compress_channel_enables;
			sh_battery_power_limiter  <= power_limit_config;
			sh_mix   <= mixer_enables;
			sh_feat  <= protection_feature_enables;
			sh_thr   <= undervoltage_threshold;
		end
	end

	// ==================================================
	// Pin synchroniser for limiter GPIO
	wire gpio_sync;
	adpc_sync u_gpio_sync (
		.clk_in    (clk_in),
		.srst_in   (srst_in),
		.pin_in    (limiter_gpio_in),
		.level_out (gpio_sync)
	);

	// ==================================================
	// Peak limiter input selection
	function [SAMPLE_W-1:0] pick_peak;
		input [1:0]          sel;
		input [SAMPLE_W-1:0] a0;
		input [SAMPLE_W-1:0] a1;
		reg   [SAMPLE_W:0]   sum;
		begin
			sum = {1'b0, a0} + {1'b0, a1};
			case (sel)
				2'h0: pick_peak = (a0 > a1) ? a0 : a1;
				2'h1: pick_peak = a1;
				2'h2: pick_peak = a0;
				default: pick_peak = sum[SAMPLE_W:1];
			endcase
		end
	endfunction

	// Table from analog pin level to attenuation code; low pin means weak battery
	function [2:0] pin_lut;
		input [7:0] v;
		begin
			pin_lut = 3'h7 - v[7:5];
		end
	endfunction

	// ==================================================
	// Battery limiter attenuation tracking
	wire [1:0] lim_in_sel  = sh_route[`ADPC_LIM_IN_HI:`ADPC_LIM_IN_LO];
	wire [1:0] lim_out_sel = sh_route[`ADPC_LIM_OUT_HI:`ADPC_LIM_OUT_LO];
	wire       battery_power_limiter_en     = sh_battery_power_limiter[`ADPC_BATTERY_POWER_LIMITER_EN];
	wire [2:0] battery_power_limiter_field  = sh_battery_power_limiter[`ADPC_BATTERY_POWER_LIMITER_ATTN_HI:`ADPC_BATTERY_POWER_LIMITER_ATTN_LO];
	wire       battery_power_limiter_by_pin = sh_battery_power_limiter[`ADPC_BATTERY_POWER_LIMITER_BY_PIN];
	wire       battery_power_limiter_recov  = sh_battery_power_limiter[`ADPC_BATTERY_POWER_LIMITER_RECOVER];
	wire [7:0] supply_sel  = sh_feat[`ADPC_FEAT_SUPPLY] ?
		analog_supply_sample_in : battery_sample_in; // see [R15]

	reg  [2:0] attn;
	reg  [2:0] target;
	reg        recovered;
	always @* begin
		if (battery_power_limiter_by_pin) begin // see [R8]
			target    = pin_lut(analog_pin_sample_in);
			recovered = (target < attn);
		end else begin
			target    = gpio_sync ? battery_power_limiter_field : 3'h0;
			recovered = ~gpio_sync;
		end
	end

	always @(posedge clk_in) begin
		if (srst_in) begin
			attn <= 3'h0;
		end else if (!battery_power_limiter_en) begin // see [R6]
			attn <= 3'h0;
		end else if (sample_tick_in) begin
			if (target > attn) begin
				attn <= target;
			end else if (battery_power_limiter_recov && recovered && target < attn) begin // see [R9]
				attn <= target;
			end
		end
	end

	// ==================================================
	// Output registers
	always @(posedge clk_in) begin
		if (srst_in) begin
			peak_level_out                  <= {SAMPLE_W{1'b0}};
			limit_ch0_out                   <= 1'b0;
			limit_ch1_out                   <= 1'b0;
			gain_ctrl_on_out                <= 4'h0;
			compress_on_out                 <= 4'h0;
			battery_limiter_on_out          <= 1'b0;
			battery_limiter_attenuation_out <= 3'h0;
			attenuation_db_out              <= 6'h00;
			mixer_on_out                    <= 4'h0;
			distortion_on_out               <= 1'b0;
			battery_overprotect_on_out      <= 1'b0;
			thermal_foldback_on_out         <= 1'b0;
			range_compressor_on_out         <= 1'b0;
			generator1_on_out               <= 1'b0;
			generator2_on_out               <= 1'b0;
			supply_measure_out              <= 8'h00;
			undervoltage_shutdown_out       <= 1'b0;
		end else begin
			peak_level_out <= pick_peak(lim_in_sel, playback_input_zero,
				playback_input_one); // see [R1]
			limit_ch0_out <= (lim_out_sel == 2'h0) || (lim_out_sel == 2'h2); // see [R2]
			limit_ch1_out <= (lim_out_sel == 2'h0) || (lim_out_sel == 2'h1); // see [R2]
			gain_ctrl_on_out <= sh_gain[7:4]; // see [R4]
			compress_on_out  <= sh_gain[3:0]; // see [R5]
			battery_limiter_on_out          <= battery_power_limiter_en; // see [R6]
			battery_limiter_attenuation_out <= attn; // see [R7]
			attenuation_db_out              <= {attn, 1'b0} + {1'b0, attn, 2'b00}; // see [R7]
			mixer_on_out <= sh_mix[7:4]; // see [R10]
			distortion_on_out          <= sh_feat[`ADPC_FEAT_DIST]; // see [R11]
			battery_overprotect_on_out <= sh_feat[`ADPC_FEAT_BOP]; // see [R12]
			range_compressor_on_out    <= sh_feat[`ADPC_FEAT_DRC]; // see [R12]
			thermal_foldback_on_out    <= sh_feat[`ADPC_FEAT_THERM]; // see [R13]
			generator1_on_out          <= sh_feat[`ADPC_FEAT_GEN1]; // see [R14]
			generator2_on_out          <= sh_feat[`ADPC_FEAT_GEN2]; // see [R14]
			supply_measure_out         <= supply_sel; // see [R15]
			// Shutdown latches until disabled; a recovering supply does not restart
			if (!sh_feat[`ADPC_FEAT_BROWN]) begin // see [R16]
				undervoltage_shutdown_out <= 1'b0;
			end else if (supply_sel < sh_thr) begin // see [R17]
				undervoltage_shutdown_out <= 1'b1;
			end
		end
	end
endmodule // adpc_top
`default_nettype wire

/* File: pkg/adpc_consts.vh */
`ifndef ADPC_CONSTS_VH
`define ADPC_CONSTS_VH
// ==================================================
// Register addresses
`define ADPC_ADDR_LIMITER      8'h23
`define ADPC_ADDR_GAIN_COMP    8'h24
`define ADPC_ADDR_BATTERY_POWER_LIMITER         8'h2B
`define ADPC_ADDR_MIXER        8'h2C
`define ADPC_ADDR_FEATURE      8'h2D
`define ADPC_ADDR_THRESHOLD    8'h2E
// ==================================================
// Reset values
`define ADPC_RST_LIMITER       8'h00
`define ADPC_RST_GAIN_COMP     8'h00
`define ADPC_RST_BATTERY_POWER_LIMITER          8'h00
`define ADPC_RST_MIXER         8'h00
`define ADPC_RST_FEATURE       8'h00
`define ADPC_RST_THRESHOLD     8'hBF
// ==================================================
// Writable bit masks, reserved bits cleared
`define ADPC_MASK_LIMITER      8'hF0
`define ADPC_MASK_BATTERY_POWER_LIMITER         8'hFC
`define ADPC_MASK_MIXER        8'hF0
// ==================================================
// Field positions
`define ADPC_LIM_IN_HI         7
`define ADPC_LIM_IN_LO         6
`define ADPC_LIM_OUT_HI        5
`define ADPC_LIM_OUT_LO        4
`define ADPC_BATTERY_POWER_LIMITER_EN           7
`define ADPC_BATTERY_POWER_LIMITER_ATTN_HI      6
`define ADPC_BATTERY_POWER_LIMITER_ATTN_LO      4
`define ADPC_BATTERY_POWER_LIMITER_BY_PIN       3
`define ADPC_BATTERY_POWER_LIMITER_RECOVER      2
`define ADPC_FEAT_DIST         7
`define ADPC_FEAT_BOP          6
`define ADPC_FEAT_THERM        5
`define ADPC_FEAT_DRC          4
`define ADPC_FEAT_GEN1         3
`define ADPC_FEAT_GEN2         2
`define ADPC_FEAT_SUPPLY       1
`define ADPC_FEAT_BROWN        0
// ==================================================
// Timing
`define ADPC_SYNC_STAGES       3
`endif

/* File: hw/adpc_sync.v */
`default_nettype none
// ==================================================
// Three-stage pin synchroniser, change taken when stages two and three agree
module adpc_sync (
	// Clock and reset
	input  wire clk_in,
	input  wire srst_in,
	// Pin and result
	input  wire pin_in,
	output reg  level_out
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge clk_in) begin
		if (srst_in) begin
			s1        <= 1'b0;
			s2        <= 1'b0;
			s3        <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level_out <= s3;
			end
		end
	end
endmodule // adpc_sync
`default_nettype wire

/* File: dv/adpc_monitor.sv */
`default_nettype none
// ==========
// Port checker
module adpc_monitor (
	// Clock and inputs
	input wire logic       clk_in,
	input wire logic       srst_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       sample_tick_in,
	// Outputs
	input wire logic [7:0] reg_rdata_out,
	input wire logic       reg_hit_out,
	input wire logic [3:0] gain_ctrl_on_out,
	input wire logic [3:0] mixer_on_out,
	input wire logic       distortion_on_out,
	input wire logic       battery_limiter_on_out,
	input wire logic [2:0] battery_limiter_attenuation_out,
	input wire logic [5:0] attenuation_db_out,
	input wire logic       undervoltage_shutdown_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Ticks seen at the last three edges
	logic [2:0] tk;
	always @(posedge clk_in) tk <= srst_in ? 3'h0 : {tk[1:0], sample_tick_in};
	a_dist_tick_only: assert property (tk == 3'h0 |-> $stable(distortion_on_out))
		else $error("distortion enable moved without a tick");
	a_gain_held: assert property ((!sample_tick_in)[*3] |=> $stable(gain_ctrl_on_out))
		else $error("gain enables moved without a tick");
	a_mixer_held: assert property (tk == 3'h0 |-> mixer_on_out == $past(mixer_on_out))
		else $error("mixer enables moved without a tick");
	a_db_six_steps: assert property (attenuation_db_out ==
		{3'h0, battery_limiter_attenuation_out} * 6'h06)
		else $error("attenuation dB not six per step");
	a_off_zero_atten: assert property (!battery_limiter_on_out [*2] |->
		battery_limiter_attenuation_out == 3'h0)
		else $error("attenuation while limiter off");
	a_atten_at_tick: assert property ($changed(battery_limiter_attenuation_out) |-> tk != 3'h0
		|| !battery_limiter_on_out || $past(battery_limiter_on_out) == 1'b0)
		else $error("attenuation stepped off a tick");
	a_unmapped_zero: assert property (reg_rd_in && !(reg_addr_in inside {8'h23, 8'h24, [8'h2B:8'h2E]})
		|=> !reg_hit_out && reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_mapped_hit: assert property (reg_rd_in && reg_addr_in inside {8'h23, 8'h24, [8'h2B:8'h2E]}
		|=> reg_hit_out)
		else $error("mapped read missed");
	a_resv_read_zero: assert property (reg_rd_in && reg_addr_in inside {8'h23, 8'h2C}
		|=> reg_rdata_out[3:0] == 4'h0)
		else $error("reserved bits read nonzero");
	a_trip_sticky: assert property (undervoltage_shutdown_out && tk == 3'h0 && !sample_tick_in
		|=> undervoltage_shutdown_out)
		else $error("shutdown dropped without a tick");
	c_thr_read: cover property (reg_rd_in && reg_addr_in == 8'h2E);
	c_trip: cover property ($rose(undervoltage_shutdown_out));
	c_table_code: cover property (battery_limiter_attenuation_out == 3'h6);
endmodule // adpc_monitor
bind adpc_top adpc_monitor u_mon (.clk_in, .srst_in, .reg_rd_in, .reg_addr_in, .sample_tick_in,
	.reg_rdata_out, .reg_hit_out, .gain_ctrl_on_out, .mixer_on_out, .distortion_on_out,
	.battery_limiter_on_out, .battery_limiter_attenuation_out, .attenuation_db_out,
	.undervoltage_shutdown_out);
`default_nettype wire

/* File: dv/audio_dsp_protection_config_tb_top.sv */
`default_nettype none
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
module audio_dsp_protection_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Signals
	logic        clk_in, srst_in, reg_wr_in, reg_rd_in, sample_tick_in, limiter_gpio_in;
	logic [7:0]  reg_addr_in, reg_wdata_in, analog_pin_sample_in;
	logic [7:0]  battery_sample_in, analog_supply_sample_in;
	logic [15:0] playback_input_zero, playback_input_one;
	wire  [15:0] peak_level_out;
	wire         limit_ch0_out, limit_ch1_out, distortion_on_out, battery_overprotect_on_out;
	wire         thermal_foldback_on_out, range_compressor_on_out, generator1_on_out;
	wire         generator2_on_out, battery_limiter_on_out, undervoltage_shutdown_out, reg_hit_out;
	wire  [3:0]  gain_ctrl_on_out, compress_on_out, mixer_on_out;
	wire  [2:0]  battery_limiter_attenuation_out;
	wire  [5:0]  attenuation_db_out;
	wire  [7:0]  reg_rdata_out, supply_measure_out;
	wire  [54:0] outs = {peak_level_out, limit_ch0_out, limit_ch1_out, gain_ctrl_on_out,
		compress_on_out, mixer_on_out, distortion_on_out, battery_overprotect_on_out,
		thermal_foldback_on_out, range_compressor_on_out, generator1_on_out, generator2_on_out,
		battery_limiter_on_out, battery_limiter_attenuation_out, attenuation_db_out,
		supply_measure_out, undervoltage_shutdown_out};
	logic [8:0]  qr[$];
	logic [54:0] qo[$];
	logic [54:0] pv;
	logic [7:0]  sh[16];
	logic [7:0]  ad[6];
	int          n_mismatch, n_compared, i;
	integer      seed;
	logic        rd_d;
	event        ev_o;
	adpc_top DUT (.*);
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// ==========
	// Helpers; the bench mirrors each register with reserved bits cleared
	function [7:0] msk(input [7:0] a);
		msk = (a == 8'h23 || a == 8'h2C) ? 8'hF0 : (a == 8'h2B) ? 8'hFC : 8'hFF;
	endfunction
	function [54:0] ev(input [2:0] at, input uv);
		logic [16:0] s;
		logic [15:0] pk;
		begin
			s = playback_input_zero + playback_input_one;
			case (sh[3][7:6])
				2'h0: pk = (s[15:0] == 16'h0 && s[16] == 1'b0) ? 16'h0 : (playback_input_one <
					playback_input_zero) ? playback_input_zero : playback_input_one;
				2'h1: pk = playback_input_one;
				2'h2: pk = playback_input_zero;
				default: pk = s[16:1];
			endcase
			ev = {pk, !sh[3][4], !sh[3][5], sh[4], sh[12][7:4], sh[13][7:2], sh[11][7], at,
				{3'h0, at} * 6'h06, sh[13][1] ? analog_supply_sample_in : battery_sample_in, uv};
		end
	endfunction
	// Strobes drop for a cycle so no signal is set twice in one step
	task wr(input [7:0] a, input [7:0] d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		sh[a[3:0]] = d & msk(a);
		@(negedge clk_in) reg_wr_in = 1'b0;
		@(negedge clk_in);
	endtask
	task rd(input [7:0] a, input h, input [7:0] e);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		qr.push_back({h, e});
		@(negedge clk_in) reg_rd_in = 1'b0;
		@(negedge clk_in);
	endtask
	// Two ticks: the synchronised pin may miss the first one
	task tick;
		repeat (2) begin
			sample_tick_in = 1'b1;
			@(negedge clk_in) sample_tick_in = 1'b0;
			repeat (3) @(negedge clk_in);
		end
	endtask
	task chk(input [54:0] e);
		qo.push_back(e);
		->ev_o;
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// Watchers
	always @(posedge clk_in) rd_d <= reg_rd_in;
	always @(negedge clk_in) if (rd_d === 1'b1) `CMP({reg_hit_out, reg_rdata_out}, qr.pop_front())
	always @(ev_o) `CMP(outs, qo.pop_front())
	// Run is a few hundred cycles; this margin only catches a hang
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		seed = 32'h44a3;
		srst_in = 1'b1;
		{reg_wr_in, reg_rd_in, sample_tick_in, limiter_gpio_in, reg_addr_in, reg_wdata_in} = 0;
		{analog_pin_sample_in, battery_sample_in, analog_supply_sample_in} = 24'hFFF0F0;
		playback_input_zero = $random(seed);
		playback_input_one = $random(seed);
		foreach (sh[j]) sh[j] = 8'h00;
		sh[14] = 8'hBF;
		ad = '{8'h23, 8'h24, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		foreach (ad[j]) rd(ad[j], 1'b1, sh[ad[j][3:0]]);
		wr(8'h25, 8'hFF);
		rd(8'h25, 1'b0, 8'h00);
		foreach (ad[j]) begin
			wr(ad[j], $random(seed));
			rd(ad[j], 1'b1, sh[ad[j][3:0]]);
		end
		wr(8'h2B, 8'h00);
		wr(8'h2E, 8'h00);
		tick;
		for (i = 0; i < 4; i++) begin
			pv = ev(3'h0, 1'b0);
			wr(8'h23, {i[1:0], i[1:0], 4'h0});
			wr(8'h24, $random(seed));
			wr(8'h2C, $random(seed));
			wr(8'h2D, 8'hFE & $random(seed));
			chk(pv);
			tick;
			chk(ev(3'h0, 1'b0));
		end
		limiter_gpio_in = 1'b1;
		wr(8'h2B, 8'hD0);
		tick;
		chk(ev(3'h5, 1'b0));
		limiter_gpio_in = 1'b0;
		tick;
		chk(ev(3'h5, 1'b0));
		wr(8'h2B, 8'hD4);
		tick;
		chk(ev(3'h0, 1'b0));
		analog_pin_sample_in = 8'h20;
		wr(8'h2B, 8'h88);
		tick;
		chk(ev(3'h6, 1'b0));
		wr(8'h2B, 8'h00);
		tick;
		chk(ev(3'h0, 1'b0));
		wr(8'h2E, 8'hBF);
		battery_sample_in = 8'h10;
		wr(8'h2D, 8'h01);
		tick;
		chk(ev(3'h0, 1'b1));
		wr(8'h2D, 8'h03);
		tick;
		chk(ev(3'h0, 1'b1));
		wr(8'h2D, 8'h02);
		tick;
		chk(ev(3'h0, 1'b0));
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		rd(8'h2E, 1'b1, 8'hBF);
		repeat (2) @(negedge clk_in);
		tally_and_finish;
	end
endmodule // audio_dsp_protection_config_tb_top
`default_nettype wire
